// ===== inc/gef_consts.svh
`ifndef GEF_CONSTS_SVH
`define GEF_CONSTS_SVH

// register locations
`define GEF_A_ENABLE   8'h80
`define GEF_A_CFG1     8'h8D
`define GEF_A_CFG2     8'h90
`define GEF_A_STATUS   8'h93
`define GEF_A_ENTRY    8'hA0
`define GEF_A_EXIT     8'hA1
`define GEF_A_FIFOCFG  8'hA2
`define GEF_A_GAINCFG  8'hA3
`define GEF_A_OFF_UP   8'hA4
`define GEF_A_OFF_DN   8'hA5
`define GEF_A_PULSE    8'hA6
`define GEF_A_OFF_LT   8'hA7
`define GEF_A_OFF_RT   8'hA9
`define GEF_A_DIMCFG   8'hAA
`define GEF_A_MODE     8'hAB
`define GEF_A_LEVEL    8'hAE
`define GEF_A_FLAGS    8'hAF
`define GEF_A_FIFO_UP  8'hFC
`define GEF_A_FIFO_DN  8'hFD
`define GEF_A_FIFO_LT  8'hFE
`define GEF_A_FIFO_RT  8'hFF

// bit and field positions
`define GEF_B_PON      0
`define GEF_B_GEN      6
`define GEF_B_GMODE    0
`define GEF_B_GIEN     1
`define GEF_B_FCLR     2
`define GEF_B_VALID    0
`define GEF_B_OVF      1
`define GEF_B_SAT      6
`define GEF_F_FTH      7:6
`define GEF_F_EXPERS   1:0
`define GEF_F_GAIN     6:5
`define GEF_F_LDRV     4:3
`define GEF_F_WTIME    2:0
`define GEF_F_BOOST    5:4
`define GEF_F_PCNT     5:0
`define GEF_F_PLEN     7:6
`define GEF_F_DIMS     1:0
`define GEF_EXMSK_TOP  5
`define GEF_DIMS_UD    2'h1
`define GEF_WMASK_MODE 8'h03

// reset values
`define GEF_RST_CFG1   8'h60
`define GEF_RST_CFG2   8'h01
`define GEF_RST_PULSE  8'h40

// fifo threshold levels per code
`define GEF_FTH_0      8'h01
`define GEF_FTH_1      8'h04
`define GEF_FTH_2      8'h08
`define GEF_FTH_3      8'h10

// timing
`define GEF_CLK_HZ     10000000
`define GEF_PLEN_US_0  4
`define GEF_PLEN_US_1  8
`define GEF_PLEN_US_2  16
`define GEF_PLEN_US_3  32
`define GEF_WAIT_UNIT_US 1000

`endif

// ===== inc/gef_pkg.sv
`default_nettype none
package gef_pkg;

    typedef enum logic [2:0] {
        GEF_IDLE,
        GEF_ON,
        GEF_OFF,
        GEF_STORE,
        GEF_WAIT
    } gef_phase_t;

    typedef struct packed {
        logic [7:0] up;
        logic [7:0] down;
        logic [7:0] left;
        logic [7:0] right;
    } gef_set_t;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } gef_req_t;

    typedef struct packed {
        logic       on;
        logic [1:0] drive;
        logic [1:0] boost;
    } gef_led_t;

endpackage
`default_nettype wire

// ===== rtl/gef_engine.sv
// What this block does
// - gesture engine runs only while gesture enable and mode bit are set
// - mode bit host writable, also set when proximity result reaches entry
// - engine is left once the mode bit, power-on or gesture enable has returned to zero
// - exit needs every unmasked direction byte below the exit threshold
// - exit after persistence count of below datasets; above resets count
// - session without valid flag raises no interrupt and purges fifo
// - each cycle yields four bytes up down left right as one dataset
// - gain field selects signal scaling from 1/8x (code 0) to 1x (code 3)
// - per-direction offset is subtracted from accumulated signal
// - pulse count sets pulses per cycle, pulse length sets period
// - non-zero wait field inserts wait between pulse trains
// - drive field picks led current level, boost field raises it
// - fifo holds up to thirty-two datasets before overflow
// - on overflow newest dataset dropped, stored kept, overflow flag set
// - level at threshold sets valid and interrupt; pin needs enable
// - leaving engine with valid set always gives a final interrupt
// - interrupt, valid and level clear once fifo read empty or on a fifo clear
// - oldest dataset read at four consecutive locations up to right
`include "gef_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module gef_engine #(
    parameter int P_DEPTH         = 32,
    parameter int P_WAIT_UNIT_CYC =
        (`GEF_WAIT_UNIT_US * (`GEF_CLK_HZ / 1000000))
) (
    input  wire logic              i_clk,
    input  wire logic              i_arst_n,
    input  wire gef_pkg::gef_req_t i_req,
    input  wire logic              i_prox_valid,
    input  wire logic [7:0]        i_prox_result,
    input  wire gef_pkg::gef_set_t i_diode,
    output logic [7:0]             o_rdata,
    output logic                   o_int_n,
    output gef_pkg::gef_led_t      o_led,
    output logic [1:0]             o_gain,
    output logic                   o_active
);
    import gef_pkg::*;

    localparam int AW = $clog2(P_DEPTH);
    localparam int PL0_CYC =
        (`GEF_PLEN_US_0 * `GEF_CLK_HZ + 999999) / 1000000;
    localparam int PL1_CYC =
        (`GEF_PLEN_US_1 * `GEF_CLK_HZ + 999999) / 1000000;
    localparam int PL2_CYC =
        (`GEF_PLEN_US_2 * `GEF_CLK_HZ + 999999) / 1000000;
    localparam int PL3_CYC =
        (`GEF_PLEN_US_3 * `GEF_CLK_HZ + 999999) / 1000000;

    // pointer wrap relies on a power-of-two depth; level fits one byte
    if (P_DEPTH < 2 || P_DEPTH > 128 || (P_DEPTH & (P_DEPTH - 1)) != 0)
        $error("gef_engine: depth must be a power of two up to 128");
    if (P_WAIT_UNIT_CYC < 1 || P_WAIT_UNIT_CYC > 2000000)
        $error("gef_engine: wait unit out of range");

    typedef struct packed {
        gef_phase_t                ph;
        logic [23:0]               tmr;
        logic [5:0]                pcnt;
        logic [3:0][15:0]          acc;
        logic [7:0]                en;
        logic [7:0]                cfg1;
        logic [7:0]                cfg2;
        logic [7:0]                enth;
        logic [7:0]                exth;
        logic [7:0]                fcfg;
        logic [7:0]                gcfg2;
        logic [7:0]                pulse;
        logic [7:0]                dims;
        logic [7:0]                mode;
        logic [3:0][7:0]           offs;
        gef_set_t [P_DEPTH-1:0]    mem;
        logic [AW-1:0]             wp;
        logic [AW-1:0]             rp;
        logic [AW:0]               lvl;
        logic                      valid;
        logic                      motion_interrupt_flag;
        logic                      ovf;
        logic                      sat;
        logic                      seen;
        logic [1:0]                pers;
        logic [7:0]                rdata;
        logic                      int_n;
        gef_led_t                  led;
        logic                      active;
    } gef_st_t;

    gef_st_t         q;
    gef_st_t         d;
    logic            eng;
    logic            pop;
    logic            push;
    logic            clr_fifo;
    logic            leave;
    logic            below_all;
    logic [3:0][8:0] res;
    logic [3:0][7:0] dv;
    logic [3:0][7:0] sb;
    gef_set_t        set_in;
    gef_set_t        head;
    logic [23:0]     on_cyc;
    logic [23:0]     off_cyc;
    logic [23:0]     wait_cyc;
    logic [1:0]      pers_nx;

    function automatic logic [7:0] fth(input logic [1:0] code);
        logic [7:0] v;
        unique case (code)
            2'h0: v = `GEF_FTH_0;
            2'h1: v = `GEF_FTH_1;
            2'h2: v = `GEF_FTH_2;
            2'h3: v = `GEF_FTH_3;
        endcase
        return v;
    endfunction

    // bit 8 flags saturation; negative results clamp to zero
    function automatic logic [8:0] chan(input logic [15:0] a,
                                        input logic [1:0]  g,
                                        input logic [7:0]  off);
        logic [18:0]        amp;
        logic signed [19:0] v;
        amp = {3'h0, a} << g;
        v = $signed({4'h0, amp[18:3]}) - $signed({12'h000, off});
        if (v < 0)
            return 9'h000;
        else if (v > 20'sd255)
            return 9'h1FF;
        else
            return {1'b0, v[7:0]};
    endfunction

    function automatic logic [23:0] plen(input logic [1:0] code);
        logic [23:0] v;
        unique case (code)
            2'h0: v = 24'(PL0_CYC);
            2'h1: v = 24'(PL1_CYC);
            2'h2: v = 24'(PL2_CYC);
            2'h3: v = 24'(PL3_CYC);
        endcase
        return v;
    endfunction

    always_comb begin
        d = q;
        pop = 1'b0;
        push = 1'b0;
        clr_fifo = 1'b0;
        leave = 1'b0;
        below_all = 1'b1;
        eng = q.en[`GEF_B_PON] & q.en[`GEF_B_GEN] & q.mode[`GEF_B_GMODE];
        head = q.mem[q.rp];
        dv = {i_diode.right, i_diode.left, i_diode.down, i_diode.up};
        // pulse period split into on and off halves; up-down mode halves the on time again
        off_cyc = plen(q.pulse[`GEF_F_PLEN]) >> 1;
        on_cyc = off_cyc;
        if (q.dims[`GEF_F_DIMS] == `GEF_DIMS_UD)
            on_cyc = (off_cyc > 24'h1) ? (off_cyc >> 1) : 24'h1;
        wait_cyc = 24'(q.gcfg2[`GEF_F_WTIME]) * 24'(P_WAIT_UNIT_CYC);
        for (int i = 0; i < 4; i++)
            res[i] = chan(q.acc[i], q.gcfg2[`GEF_F_GAIN], q.offs[i]);
        set_in.up = res[0][7:0];
        set_in.down = res[1][7:0];
        set_in.left = res[2][7:0];
        set_in.right = res[3][7:0];
        if (q.dims[`GEF_F_DIMS] == `GEF_DIMS_UD) begin
            set_in.left = 8'h00;
            set_in.right = 8'h00;
        end
        sb = {set_in.right, set_in.left, set_in.down, set_in.up};
        // masked bytes do not take part
        for (int i = 0; i < 4; i++)
            if (!q.fcfg[`GEF_EXMSK_TOP - i] && sb[i] >= q.exth)
                below_all = 1'b0;
        pers_nx = (q.pers == 2'h3) ? 2'h3 : q.pers + 2'h1;

        if (i_req.rd) begin
            case (i_req.addr)
                `GEF_A_ENABLE:  d.rdata = q.en;
                `GEF_A_CFG1:    d.rdata = q.cfg1;
                `GEF_A_CFG2:    d.rdata = q.cfg2;
                `GEF_A_STATUS:  d.rdata = {1'b0, q.sat, 6'h00};
                `GEF_A_ENTRY:   d.rdata = q.enth;
                `GEF_A_EXIT:    d.rdata = q.exth;
                `GEF_A_FIFOCFG: d.rdata = q.fcfg;
                `GEF_A_GAINCFG: d.rdata = q.gcfg2;
                `GEF_A_OFF_UP:  d.rdata = q.offs[0];
                `GEF_A_OFF_DN:  d.rdata = q.offs[1];
                `GEF_A_OFF_LT:  d.rdata = q.offs[2];
                `GEF_A_OFF_RT:  d.rdata = q.offs[3];
                `GEF_A_PULSE:   d.rdata = q.pulse;
                `GEF_A_DIMCFG:  d.rdata = q.dims;
                `GEF_A_MODE:    d.rdata = q.mode;
                `GEF_A_LEVEL:   d.rdata = 8'(q.lvl);
                `GEF_A_FLAGS:   d.rdata = {6'h00, q.ovf, q.valid};
                `GEF_A_FIFO_UP: d.rdata = (q.lvl != 0) ? head.up : 8'h00;
                `GEF_A_FIFO_DN: d.rdata = (q.lvl != 0) ? head.down : 8'h00;
                `GEF_A_FIFO_LT: d.rdata = (q.lvl != 0) ? head.left : 8'h00;
                `GEF_A_FIFO_RT: begin
                    d.rdata = (q.lvl != 0) ? head.right : 8'h00;
                    pop = (q.lvl != 0);
                end
                default:        d.rdata = 8'h00;
            endcase
        end
        // right byte read retires the dataset
        if (pop) begin
            d.rp = q.rp + 1'b1;
            d.lvl = q.lvl - 1'b1;
        end

        if (i_req.wr) begin
            case (i_req.addr)
                `GEF_A_ENABLE:  d.en = i_req.wdata;
                `GEF_A_CFG1:    d.cfg1 = i_req.wdata;
                `GEF_A_CFG2:    d.cfg2 = i_req.wdata;
                `GEF_A_ENTRY:   d.enth = i_req.wdata;
                `GEF_A_EXIT:    d.exth = i_req.wdata;
                `GEF_A_FIFOCFG: d.fcfg = i_req.wdata;
                `GEF_A_GAINCFG: d.gcfg2 = i_req.wdata;
                `GEF_A_OFF_UP:  d.offs[0] = i_req.wdata;
                `GEF_A_OFF_DN:  d.offs[1] = i_req.wdata;
                `GEF_A_OFF_LT:  d.offs[2] = i_req.wdata;
                `GEF_A_OFF_RT:  d.offs[3] = i_req.wdata;
                `GEF_A_PULSE:   d.pulse = i_req.wdata;
                `GEF_A_DIMCFG:  d.dims = i_req.wdata & 8'h03;
                `GEF_A_MODE: begin
                    d.mode = i_req.wdata & `GEF_WMASK_MODE;
                    clr_fifo = i_req.wdata[`GEF_B_FCLR];
                end
                default: ;
            endcase
        end
        // automatic entry, wins over a host clear
        if (i_prox_valid && i_prox_result >= q.enth)
            d.mode[`GEF_B_GMODE] = 1'b1;

        if (clr_fifo) begin
            d.wp = '0;
            d.rp = '0;
            d.lvl = '0;
            d.valid = 1'b0;
            d.motion_interrupt_flag = 1'b0;
            d.ovf = 1'b0;
            d.sat = 1'b0;
        end else if (pop && d.lvl == 0) begin
            d.valid = 1'b0;
            d.motion_interrupt_flag = 1'b0;
        end

        // host clear of mode ends the session
        if (q.ph != GEF_IDLE && !eng) begin
            leave = 1'b1;
        end else begin
            unique case (q.ph)
                GEF_IDLE: begin
                    if (eng) begin
                        d.ph = GEF_ON;
                        d.tmr = on_cyc;
                        d.pcnt = '0;
                        d.acc = '0;
                        d.seen = 1'b0;
                        d.pers = '0;
                    end
                end
                GEF_ON: begin
                    if (q.tmr <= 24'h1) begin
                        for (int i = 0; i < 4; i++)
                            d.acc[i] = q.acc[i] + 16'(dv[i]);
                        d.ph = GEF_OFF;
                        d.tmr = off_cyc;
                    end else begin
                        d.tmr = q.tmr - 24'h1;
                    end
                end
                GEF_OFF: begin
                    if (q.tmr > 24'h1) begin
                        d.tmr = q.tmr - 24'h1;
                    end else if (q.pcnt == q.pulse[`GEF_F_PCNT]) begin
                        d.ph = GEF_STORE;
                    end else begin
                        d.pcnt = q.pcnt + 6'h1;
                        d.ph = GEF_ON;
                        d.tmr = on_cyc;
                    end
                end
                GEF_STORE: begin
                    push = 1'b1;
                    if (res[0][8] | res[1][8] | res[2][8] | res[3][8])
                        d.sat = 1'b1;
                    d.pers = below_all ? pers_nx : 2'h0;
                    if (below_all && pers_nx >= q.fcfg[`GEF_F_EXPERS]
                        && !(i_prox_valid && i_prox_result >= q.enth)) begin
                        d.mode[`GEF_B_GMODE] = 1'b0;
                        leave = 1'b1;
                    end else if (wait_cyc == 24'h0) begin
                        d.ph = GEF_ON;
                        d.tmr = on_cyc;
                        d.pcnt = '0;
                        d.acc = '0;
                    end else begin
                        d.ph = GEF_WAIT;
                        d.tmr = wait_cyc;
                    end
                end
                GEF_WAIT: begin
                    if (q.tmr <= 24'h1) begin
                        d.ph = GEF_ON;
                        d.tmr = on_cyc;
                        d.pcnt = '0;
                        d.acc = '0;
                    end else begin
                        d.tmr = q.tmr - 24'h1;
                    end
                end
            endcase
        end

        if (push) begin
            // full fifo drops the newest dataset
            if (d.lvl == (AW + 1)'(P_DEPTH)) begin
                d.ovf = 1'b1;
            end else begin
                d.mem[d.wp] = set_in;
                d.wp = d.wp + 1'b1;
                d.lvl = d.lvl + 1'b1;
            end
        end
        // level threshold sets valid and interrupt
        if (8'(d.lvl) >= fth(d.fcfg[`GEF_F_FTH])) begin
            d.valid = 1'b1;
            d.motion_interrupt_flag = 1'b1;
        end
        d.seen = d.seen | d.valid;

        if (leave) begin
            d.ph = GEF_IDLE;
            if (d.seen) begin
                d.motion_interrupt_flag = d.motion_interrupt_flag | d.valid;
            end else begin
                d.wp = '0;
                d.rp = '0;
                d.lvl = '0;
                d.motion_interrupt_flag = 1'b0;
            end
        end

        d.int_n = ~(d.motion_interrupt_flag & d.mode[`GEF_B_GIEN]);
        d.led.on = (d.ph == GEF_ON);
        // drive level and boost to led driver
        d.led.drive = d.gcfg2[`GEF_F_LDRV];
        d.led.boost = d.cfg2[`GEF_F_BOOST];
        d.active = (d.ph != GEF_IDLE);
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            q <= '0;
            q.cfg1 <= `GEF_RST_CFG1;
            q.cfg2 <= `GEF_RST_CFG2;
            q.pulse <= `GEF_RST_PULSE;
            q.int_n <= 1'b1;
            q.led.boost <= 2'h0;
        end else begin
            q <= d;
        end
    end

    assign o_rdata = q.rdata;
    assign o_int_n = q.int_n;
    assign o_led = q.led;
    assign o_gain = q.gcfg2[`GEF_F_GAIN];
    assign o_active = q.active;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    sequence s_pulse_start;
        $rose(o_led.on);
    endsequence
    sequence s_pulse_hold;
        o_led.on [*8];
    endsequence

    engine_entry_a: assert property ($rose(o_active) |->
        $past(q.mode[0] & q.en[6] & q.en[0]))
        else $error("engine entered without enable and mode");
    auto_entry_a: assert property (
        i_prox_valid && i_prox_result >= q.enth |=> q.mode[0])
        else $error("mode not set by proximity result");
    stay_in_a: assert property ($fell(o_active) |->
        !q.mode[0] || !q.en[6] || !q.en[0])
        else $error("engine left while mode still set");
    pulse_len_a: assert property (
        s_pulse_start |-> s_pulse_hold)
        else $error("led pulse shorter than minimum");
    drop_newest_a: assert property (
        push && q.lvl == (AW + 1)'(P_DEPTH) && !pop && !clr_fifo
        |=> q.ovf && q.lvl == (AW + 1)'(P_DEPTH)
            && q.wp == $past(q.wp))
        else $error("overflow did not drop dataset");
    valid_level_a: assert property (
        8'(q.lvl) >= fth(q.fcfg[7:6]) |-> q.valid && q.motion_interrupt_flag)
        else $error("valid not set at fifo threshold");
    int_pin_a: assert property (
        q.motion_interrupt_flag && q.mode[1] |-> !o_int_n)
        else $error("interrupt pin not driven");
    empty_clear_a: assert property (
        pop && q.lvl == 1 && !push |=> !q.valid && !q.motion_interrupt_flag && q.lvl == 0)
        else $error("flags not cleared on empty");
    head_order_a: assert property (
        i_req.rd && i_req.addr == 8'hFC && q.lvl != 0
        |=> o_rdata == $past(head.up))
        else $error("up byte not oldest dataset");
    pop_level_a: assert property (
        pop && !push && !clr_fifo
        |=> q.lvl == $past(q.lvl) - 1'b1)
        else $error("right read did not retire dataset");
    fifo_clear_a: assert property (
        i_req.wr && i_req.addr == 8'hAB && i_req.wdata[2] && !push
        |=> q.lvl == 0 && !q.ovf && !q.valid)
        else $error("fifo clear incomplete");
    dims_zero_a: assert property (
        push && q.dims[1:0] == 2'h1 && !clr_fifo
        && q.lvl != (AW + 1)'(P_DEPTH)
        |=> q.mem[$past(q.wp)].left == 8'h00
            && q.mem[$past(q.wp)].right == 8'h00)
        else $error("left right not zero in up-down mode");
endmodule

`default_nettype wire

// ===== dv/gef_host.sv
`timescale 1ns/1ps
`default_nettype none
module gef_host (
    input  wire logic         i_clk,
    input  wire logic [7:0]   i_rdata,
    output var gef_pkg::gef_req_t o_req
);
    import gef_pkg::*;
    initial o_req = '0;
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        o_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(negedge i_clk);
        o_req = '0;
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_clk);
        o_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(negedge i_clk);
        o_req = '0;
        d = i_rdata;
    endtask
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import gef_pkg::*;
    logic       clk = 0;
    logic       arst_n = 0;
    logic       pv = 0;
    logic [7:0] pr = 8'h00;
    logic [7:0] rdata;
    logic [7:0] rd;
    gef_req_t   req;
    gef_led_t   led;
    logic [1:0] gain;
    logic       int_n;
    logic       active;
    int         n_fail = 0;
    int         total_checks = 0;
    int         cyc = 0;
    gef_set_t   diode = '{up: 8'h40, down: 8'h30, left: 8'h20, right: 8'h10};
    always #50 clk = ~clk;
    // short wait unit keeps the run brief
    gef_engine #(.P_DEPTH(32), .P_WAIT_UNIT_CYC(4)) u_gef_engine (
        .i_clk(clk), .i_arst_n(arst_n), .i_req(req), .i_prox_valid(pv),
        .i_prox_result(pr), .i_diode(diode), .o_rdata(rdata),
        .o_int_n(int_n), .o_led(led), .o_gain(gain), .o_active(active));
    gef_host u_gef_host (.i_clk(clk), .i_rdata(rdata), .o_req(req));
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_gef_host.reg_rd(a, d);
        chk(d, exp);
    endtask
    task automatic prox(input logic [7:0] v);
        @(negedge clk);
        pv = 1'b1;
        pr = v;
        @(negedge clk);
        pv = 1'b0;
    endtask
    // hang guard, well above the expected run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            test_done();
        end
    end
    initial begin
        repeat (20) @(negedge clk);
        arst_n = 1'b1;
        rchk(8'h8D, 8'h60);
        rchk(8'h90, 8'h01);
        rchk(8'hA6, 8'h40);
        rchk(8'hAB, 8'h00);
        rchk(8'h12, 8'h00);
        chk({7'h0, active}, 8'h00);
        u_gef_host.reg_wr(8'hA3, 8'h78);
        u_gef_host.reg_wr(8'h90, 8'h31);
        u_gef_host.reg_wr(8'hA4, 8'h04);
        u_gef_host.reg_wr(8'hA6, 8'h00);
        u_gef_host.reg_wr(8'hAA, 8'hFF);
        rchk(8'hAA, 8'h03);
        u_gef_host.reg_wr(8'hAA, 8'h00);
        chk({6'h0, gain}, 8'h03);
        chk({6'h0, led.drive}, 8'h03);
        chk({6'h0, led.boost}, 8'h03);
        u_gef_host.reg_wr(8'h80, 8'h41);
        u_gef_host.reg_wr(8'hAB, 8'h01);
        repeat (3) @(negedge clk);
        chk({7'h0, active}, 8'h01);
        // fill well past depth: one set per 41 cycles
        repeat (2000) @(negedge clk);
        rchk(8'hAE, 8'h20);
        rchk(8'hAF, 8'h03);
        chk({7'h0, int_n}, 8'h01);
        u_gef_host.reg_wr(8'hAB, 8'h03);
        // host exit lands late in a pulse, not in its first cycles
        repeat (12) @(negedge clk);
        chk({7'h0, int_n}, 8'h00);
        u_gef_host.reg_wr(8'hAB, 8'h02);
        repeat (3) @(negedge clk);
        chk({7'h0, active}, 8'h00);
        chk({7'h0, int_n}, 8'h00);
        rchk(8'hFC, 8'h3C);
        rchk(8'hFD, 8'h30);
        rchk(8'hFE, 8'h20);
        rchk(8'hFF, 8'h10);
        rchk(8'hAE, 8'h1F);
        repeat (31) u_gef_host.reg_rd(8'hFF, rd);
        rchk(8'hAE, 8'h00);
        rchk(8'hAF, 8'h02);
        chk({7'h0, int_n}, 8'h01);
        rchk(8'hFF, 8'h00);
        u_gef_host.reg_wr(8'hAB, 8'h06);
        rchk(8'hAF, 8'h00);
        u_gef_host.reg_wr(8'hA0, 8'h80);
        u_gef_host.reg_wr(8'hA1, 8'hFF);
        u_gef_host.reg_wr(8'hA2, 8'hC0);
        prox(8'h7F);
        rchk(8'hAB, 8'h02);
        prox(8'h80);
        rchk(8'hAB, 8'h03);
        chk({7'h0, active}, 8'h01);
        repeat (200) @(negedge clk);
        chk({7'h0, active}, 8'h00);
        rchk(8'hAB, 8'h02);
        rchk(8'hAE, 8'h00);
        rchk(8'hAF, 8'h00);
        chk({7'h0, int_n}, 8'h01);
        // persistence three: third below set ends the session
        u_gef_host.reg_wr(8'hA2, 8'hC3);
        u_gef_host.reg_wr(8'hA3, 8'h7F);
        prox(8'h90);
        repeat (95) @(negedge clk);
        chk({7'h0, active}, 8'h01);
        repeat (55) @(negedge clk);
        chk({7'h0, active}, 8'h01);
        repeat (95) @(negedge clk);
        chk({7'h0, active}, 8'h00);
        // up-down only, two pulses, exit on first set with data kept
        u_gef_host.reg_wr(8'hA3, 8'h78);
        u_gef_host.reg_wr(8'hA2, 8'h00);
        u_gef_host.reg_wr(8'hA6, 8'h01);
        u_gef_host.reg_wr(8'hAA, 8'h01);
        u_gef_host.reg_wr(8'hAB, 8'h03);
        repeat (5) @(negedge clk);
        chk({7'h0, led.on}, 8'h01);
        repeat (10) @(negedge clk);
        chk({7'h0, led.on}, 8'h00);
        repeat (51) @(negedge clk);
        chk({7'h0, active}, 8'h00);
        chk({7'h0, int_n}, 8'h00);
        rchk(8'hFC, 8'h7C);
        rchk(8'hFD, 8'h60);
        rchk(8'hFE, 8'h00);
        rchk(8'hFF, 8'h00);
        chk({7'h0, int_n}, 8'h01);
        test_done();
    end
endmodule
`default_nettype wire
